// ---- inc/dgp_consts.vh ----
// register offsets, field positions and reset values of the dual gpio port
`ifndef DGP_CONSTS_VH
`define DGP_CONSTS_VH
`define DGP_IDX_A_DATA 4'h0
`define DGP_IDX_B_DATA 4'h1
`define DGP_IDX_A_DIR 4'h4
`define DGP_IDX_B_DIR 4'h5
`define DGP_IDX_A_PUE 4'h6
`define DGP_IDX_B_PUE 4'h7
`define DGP_A_WIDTH 6
`define DGP_B_WIDTH 8
`define DGP_BIT_INPUT_ONLY 2
`define DGP_BIT_CLOCK_SHARED 4
`define DGP_BIT_WAKEUP 6
`define DGP_BIT_OSC_PIN_EN 7
`define DGP_DIR_RESET 8'h00
`define DGP_PUE_RESET 8'h00
`define DGP_LATCH_INIT 8'h00
`endif

// ---- verilog/dgp_pin_cell.v ----
// one gpio pin: synchroniser, output buffer control and pullup gating
`timescale 1ns/1ns
module dgp_pin_cell #(
  parameter OUT_CAPABLE = 1
) (
  // clock and reset
  input wire i_mclk,
  input wire i_sys_rst,
  // control
  input wire i_latch,
  input wire i_dir,
  input wire i_pue,
  // pin
  input wire i_pin,
  output wire o_pin,
  output wire o_pin_oe,
  output wire o_pullup,
  // sampled level
  output wire o_level
);
  reg sync1_reg;
  reg sync2_reg;

  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= i_pin;
      sync2_reg <= sync1_reg;
    end
  end

  // input-only pins never drive
  assign o_pin_oe = (OUT_CAPABLE != 0) & i_dir;
  assign o_pin = i_latch;
  // pullup drops the moment the pin turns output
  assign o_pullup = i_pue & ~o_pin_oe;
  assign o_level = sync2_reg;
endmodule

// ---- verilog/dgp_top.v ----
// dual gpio port with pullups behind an avalon-mm slave
//
// Overview of operation
// - six-bit port read gives latch for outputs, pin level for inputs.
// - eight-bit port read gives latch for outputs, pin level for inputs.
// - writes to a data latch always store, regardless of direction.
// - writing an input pin's latch leaves its read value unchanged.
// - six-bit pullup on only when enabled and input; off while output.
// - eight-bit pullup on only when enabled and input; off while output.
// - cleared pullup enable keeps the pullup off in every direction.
// - six-bit pullup register holds one independent enable per pin.
// - clock pin enable with rc or internal oscillator outputs raw clock.
// - enable clear gives bit 4 as port pin; ignored for crystal options.
// - eight-bit port has latch, direction and pullup bit per pin.
// - eight-bit direction one enables the output buffer driving the latch.
// - reset clears all eight-bit port direction bits to inputs.
// - reset leaves eight-bit port data latches unchanged.
// - bit 2 of six-bit port is input only.
// - reset clears six-bit direction bits and leaves its latches alone.
// - bit 2 reads zero while the interrupt pin function is enabled.
// - bit 6 of six-bit data reads the wakeup request latch, read only.
`timescale 1ns/1ns
`include "dgp_consts.vh"
module dgp_top #(
  parameter A_WIDTH = `DGP_A_WIDTH,
  parameter B_WIDTH = `DGP_B_WIDTH
) (
  // clock and reset
  input wire i_mclk,
  input wire i_sys_rst,
  // avalon-mm slave
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output wire [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  output wire [1:0] o_avs_response,
  // system context
  input wire i_osc_is_rc_or_int,
  input wire i_undivided_osc_clock,
  input wire i_irq_pin_enable,
  input wire i_wakeup_request_latch,
  // six-bit port pins
  input wire [A_WIDTH-1:0] i_six_bit_port_pin,
  output wire [A_WIDTH-1:0] o_six_bit_port_pin,
  output wire [A_WIDTH-1:0] o_six_bit_port_pin_oe,
  output wire [A_WIDTH-1:0] o_six_bit_port_pullup,
  // eight-bit port pins
  input wire [B_WIDTH-1:0] i_eight_bit_port_pin,
  output wire [B_WIDTH-1:0] o_eight_bit_port_pin,
  output wire [B_WIDTH-1:0] o_eight_bit_port_pin_oe,
  output wire [B_WIDTH-1:0] o_eight_bit_port_pullup
);
  reg [A_WIDTH-1:0] six_bit_port_data_reg;
  reg [A_WIDTH-1:0] six_bit_port_direction_reg;
  reg [A_WIDTH-1:0] six_bit_port_pullup_enable_reg;
  reg osc_clock_pin_enable_reg;
  reg [B_WIDTH-1:0] eight_bit_port_data_reg;
  reg [B_WIDTH-1:0] eight_bit_port_direction_reg;
  reg [B_WIDTH-1:0] eight_bit_port_pullup_enable_reg;
  reg [31:0] rdata_reg;
  reg [1:0] resp_reg;
  reg ack_reg;
  reg [31:0] rdata_next;
  reg [1:0] resp_next;
  reg wakeup_sync1_reg;
  reg wakeup_sync2_reg;
  reg irq_en_sync1_reg;
  reg irq_en_sync2_reg;
  wire [A_WIDTH-1:0] a_level;
  wire [A_WIDTH-1:0] a_pin;
  wire [A_WIDTH-1:0] a_oe;
  wire [A_WIDTH-1:0] a_pull;
  wire [B_WIDTH-1:0] b_level;
  wire [A_WIDTH-1:0] a_read;
  wire [B_WIDTH-1:0] b_read;
  wire osc_out;
  wire wr_stb;
  wire rd_stb;
  wire be0;

  // reset and power-up values cut to the width of each port
  localparam [7:0] DIR_RST = `DGP_DIR_RESET;
  localparam [7:0] PUE_RST = `DGP_PUE_RESET;
  localparam [7:0] LATCH_INIT = `DGP_LATCH_INIT;
  localparam [A_WIDTH-1:0] A_DIR_RST = DIR_RST[A_WIDTH-1:0];
  localparam [B_WIDTH-1:0] B_DIR_RST = DIR_RST[B_WIDTH-1:0];
  localparam [A_WIDTH-1:0] A_PUE_RST = PUE_RST[A_WIDTH-1:0];
  localparam [B_WIDTH-1:0] B_PUE_RST = PUE_RST[B_WIDTH-1:0];
  localparam [A_WIDTH-1:0] A_LATCH_INIT = LATCH_INIT[A_WIDTH-1:0];
  localparam [B_WIDTH-1:0] B_LATCH_INIT = LATCH_INIT[B_WIDTH-1:0];

  // one wait state: a request is answered on the cycle after it appears
  // writes land at the edge that drops waitrequest, a cycle before the taking edge
  assign wr_stb = i_avs_write & ~ack_reg;
  assign rd_stb = i_avs_read & ~ack_reg;
  assign be0 = i_avs_byteenable[0];
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
  assign o_avs_readdata = rdata_reg;
  assign o_avs_response = resp_reg;

  genvar g;
  generate
    for (g = 0; g < A_WIDTH; g = g + 1)
    begin : g_a
      dgp_pin_cell #(
        .OUT_CAPABLE(g != `DGP_BIT_INPUT_ONLY)
      ) u_cell (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_latch(six_bit_port_data_reg[g]),
        .i_dir(six_bit_port_direction_reg[g]),
        .i_pue(six_bit_port_pullup_enable_reg[g]),
        .i_pin(i_six_bit_port_pin[g]),
        .o_pin(a_pin[g]),
        .o_pin_oe(a_oe[g]),
        .o_pullup(a_pull[g]),
        .o_level(a_level[g])
      );
      // read mux: latch for outputs, synced pin for inputs
      assign a_read[g] = a_oe[g] ? six_bit_port_data_reg[g] : a_level[g];
    end
    for (g = 0; g < B_WIDTH; g = g + 1)
    begin : g_b
      dgp_pin_cell #(
        .OUT_CAPABLE(1)
      ) u_cell (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_latch(eight_bit_port_data_reg[g]),
        .i_dir(eight_bit_port_direction_reg[g]),
        .i_pue(eight_bit_port_pullup_enable_reg[g]),
        .i_pin(i_eight_bit_port_pin[g]),
        .o_pin(o_eight_bit_port_pin[g]),
        .o_pin_oe(o_eight_bit_port_pin_oe[g]),
        .o_pullup(o_eight_bit_port_pullup[g]),
        .o_level(b_level[g])
      );
      assign b_read[g] = eight_bit_port_direction_reg[g] ?
        eight_bit_port_data_reg[g] : b_level[g];
    end
  endgenerate

  // shared pin carries the raw clock only with rc or internal oscillator
  assign osc_out = osc_clock_pin_enable_reg & i_osc_is_rc_or_int;
  generate
    for (g = 0; g < A_WIDTH; g = g + 1)
    begin : g_a_out
      if (g == `DGP_BIT_CLOCK_SHARED)
      begin : g_shared
        // clock bypasses the latch; a plain port bit otherwise
        assign o_six_bit_port_pin[g] = osc_out ?
          i_undivided_osc_clock : a_pin[g];
        assign o_six_bit_port_pin_oe[g] = osc_out | a_oe[g];
        assign o_six_bit_port_pullup[g] = ~osc_out & a_pull[g];
      end
      else
      begin : g_plain
        assign o_six_bit_port_pin[g] = a_pin[g];
        assign o_six_bit_port_pin_oe[g] = a_oe[g];
        assign o_six_bit_port_pullup[g] = a_pull[g];
      end
    end
  endgenerate

  // context levels come from other logic; synchronised to be safe
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wakeup_sync1_reg <= 1'b0;
      wakeup_sync2_reg <= 1'b0;
      irq_en_sync1_reg <= 1'b0;
      irq_en_sync2_reg <= 1'b0;
    end
    else
    begin
      wakeup_sync1_reg <= i_wakeup_request_latch;
      wakeup_sync2_reg <= wakeup_sync1_reg;
      irq_en_sync1_reg <= i_irq_pin_enable;
      irq_en_sync2_reg <= irq_en_sync1_reg;
    end
  end

  // read data assembly
  always @*
  begin
    rdata_next = 32'h00000000;
    resp_next = 2'h0;
    if (i_avs_address == `DGP_IDX_A_DATA)
    begin
      rdata_next[A_WIDTH-1:0] = a_read;
      if (irq_en_sync2_reg)
        rdata_next[`DGP_BIT_INPUT_ONLY] = 1'b0;
      else
        rdata_next[`DGP_BIT_INPUT_ONLY] =
          a_level[`DGP_BIT_INPUT_ONLY];
      rdata_next[`DGP_BIT_WAKEUP] = wakeup_sync2_reg;
    end
    else if (i_avs_address == `DGP_IDX_B_DATA)
      rdata_next[B_WIDTH-1:0] = b_read;
    else if (i_avs_address == `DGP_IDX_A_DIR)
      rdata_next[A_WIDTH-1:0] = six_bit_port_direction_reg;
    else if (i_avs_address == `DGP_IDX_B_DIR)
      rdata_next[B_WIDTH-1:0] = eight_bit_port_direction_reg;
    else if (i_avs_address == `DGP_IDX_A_PUE)
    begin
      rdata_next[A_WIDTH-1:0] = six_bit_port_pullup_enable_reg;
      rdata_next[`DGP_BIT_OSC_PIN_EN] = osc_clock_pin_enable_reg;
    end
    else if (i_avs_address == `DGP_IDX_B_PUE)
      rdata_next[B_WIDTH-1:0] = eight_bit_port_pullup_enable_reg;
    else
      resp_next = 2'h2;
  end

  // bus handshake and response
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      resp_reg <= 2'h0;
    end
    else
    begin
      ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
      if (rd_stb)
        rdata_reg <= rdata_next;
      if (rd_stb | wr_stb)
        resp_reg <= resp_next;
    end
  end

  // direction registers: reset turns every pin into an input
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      six_bit_port_direction_reg <= A_DIR_RST;
      eight_bit_port_direction_reg <= B_DIR_RST;
    end
    else if (wr_stb & be0)
    begin
      if (i_avs_address == `DGP_IDX_A_DIR)
        six_bit_port_direction_reg <= i_avs_writedata[A_WIDTH-1:0];
      else if (i_avs_address == `DGP_IDX_B_DIR)
        eight_bit_port_direction_reg <= i_avs_writedata[B_WIDTH-1:0];
    end
  end

  // pullup enables and the clock pin enable start cleared
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      six_bit_port_pullup_enable_reg <= A_PUE_RST;
      eight_bit_port_pullup_enable_reg <= B_PUE_RST;
      osc_clock_pin_enable_reg <= 1'b0;
    end
    else if (wr_stb & be0)
    begin
      if (i_avs_address == `DGP_IDX_A_PUE)
      begin
        six_bit_port_pullup_enable_reg <=
          i_avs_writedata[A_WIDTH-1:0];
        osc_clock_pin_enable_reg <=
          i_avs_writedata[`DGP_BIT_OSC_PIN_EN];
      end
      else if (i_avs_address == `DGP_IDX_B_PUE)
        eight_bit_port_pullup_enable_reg <=
          i_avs_writedata[B_WIDTH-1:0];
    end
  end

  // data latches sit outside reset, as a port latch keeps its value;
  // an initial value only keeps simulation out of unknowns
  initial
  begin
    six_bit_port_data_reg = A_LATCH_INIT;
    eight_bit_port_data_reg = B_LATCH_INIT;
  end

  always @(posedge i_mclk)
  begin
    if (wr_stb & be0)
    begin
      // stored whatever the direction; the pin drives it only as output
      if (i_avs_address == `DGP_IDX_A_DATA)
        six_bit_port_data_reg <= i_avs_writedata[A_WIDTH-1:0];
      if (i_avs_address == `DGP_IDX_B_DATA)
        eight_bit_port_data_reg <= i_avs_writedata[B_WIDTH-1:0];
    end
  end
  // latch-first ordering before turning to output is up to software
endmodule

// ---- tb/dgp_top_monitor.sv ----
// concurrent checks on the ports of the dual gpio port
`timescale 1ns/1ns
module dgp_mon #(
  parameter A_WIDTH = 6,
  parameter B_WIDTH = 8
) (
  input wire i_mclk,
  input wire i_sys_rst,
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  input wire i_irq_pin_enable,
  input wire [A_WIDTH-1:0] o_six_bit_port_pin,
  input wire [A_WIDTH-1:0] o_six_bit_port_pin_oe,
  input wire [A_WIDTH-1:0] o_six_bit_port_pullup,
  input wire [B_WIDTH-1:0] o_eight_bit_port_pin,
  input wire [B_WIDTH-1:0] o_eight_bit_port_pin_oe,
  input wire [B_WIDTH-1:0] o_eight_bit_port_pullup
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  wire wr_ok = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  wire rd_ok = i_avs_read && !o_avs_waitrequest;
  a_b_dir_oe: assert property (wr_ok && i_avs_address == 4'h5 |->
    o_eight_bit_port_pin_oe == i_avs_writedata[7:0]) else $error("b oe");
  a_b_latch_out: assert property (wr_ok && i_avs_address == 4'h1 |->
    o_eight_bit_port_pin == i_avs_writedata[7:0]) else $error("b latch");
  a_b_pull_gate: assert property (
    (o_eight_bit_port_pullup & o_eight_bit_port_pin_oe) == 8'h00)
    else $error("b pullup on output");
  a_a_pull_gate: assert property (
    (o_six_bit_port_pullup & o_six_bit_port_pin_oe) == 6'h00)
    else $error("a pullup on output");
  a_input_only: assert property (!o_six_bit_port_pin_oe[2])
    else $error("bit 2 driven");
  a_b_read_mux: assert property (rd_ok && i_avs_address == 4'h1 |->
    ((o_avs_readdata[7:0] ^ o_eight_bit_port_pin) &
    o_eight_bit_port_pin_oe) == 8'h00) else $error("b read");
  a_a_read_mux: assert property (rd_ok && i_avs_address == 4'h0 |->
    ((o_avs_readdata[5:0] ^ o_six_bit_port_pin) &
    o_six_bit_port_pin_oe & 6'h2F) == 6'h00) else $error("a read");
  a_irq_zero: assert property (rd_ok && i_avs_address == 4'h0 &&
    i_irq_pin_enable && $past(i_irq_pin_enable, 4) |->
    !o_avs_readdata[2]) else $error("bit 2 not zero");
endmodule
bind dgp_top dgp_mon #(.A_WIDTH(A_WIDTH), .B_WIDTH(B_WIDTH)) u_mon (
  .i_mclk, .i_sys_rst, .i_avs_address, .i_avs_read, .i_avs_write,
  .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
  .i_irq_pin_enable, .o_six_bit_port_pin, .o_six_bit_port_pin_oe,
  .o_six_bit_port_pullup, .o_eight_bit_port_pin, .o_eight_bit_port_pin_oe,
  .o_eight_bit_port_pullup);

// ---- tb/dgp_board.sv ----
// board side of the gpio pins: drivers, pullups and floating lines
`timescale 1ns/1ns
module dgp_board #(
  parameter W = 8
) (
  input wire i_mclk,
  input wire [W-1:0] i_out,
  input wire [W-1:0] i_oe,
  input wire [W-1:0] i_pullup,
  input wire [W-1:0] i_ext_en,
  input wire [W-1:0] i_ext_val,
  output wire [W-1:0] o_level
);
  // a floating line toggles so that it never reads as a steady level
  reg [W-1:0] float_reg = {W{1'b0}};
  always @(posedge i_mclk)
    float_reg <= ~float_reg;
  // the board releases a pin wherever the port drives it
  assign o_level = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val) |
    (~i_oe & ~i_ext_en & (i_pullup | float_reg));
endmodule

// ---- tb/dgp_testbench.sv ----
// self-checking bench for the dual gpio port
`timescale 1ns/1ns
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module testbench;
  reg i_mclk = 1'b0;
  reg i_sys_rst = 1'b1;
  reg [3:0] i_avs_address = 4'h0;
  reg i_avs_read = 1'b0;
  reg i_avs_write = 1'b0;
  reg [31:0] i_avs_writedata = 32'h0;
  reg [3:0] i_avs_byteenable = 4'hF;
  reg i_osc_is_rc_or_int = 1'b0;
  reg i_undivided_osc_clock = 1'b0;
  reg i_irq_pin_enable = 1'b0;
  reg i_wakeup_request_latch = 1'b0;
  reg [5:0] a_en = 6'h00, a_val = 6'h00;
  reg [7:0] b_en = 8'h00, b_val = 8'h00;
  reg [31:0] rdata;
  reg [1:0] rresp;
  int error_cnt = 0;
  int compares = 0;
  wire [31:0] o_avs_readdata;
  wire o_avs_waitrequest;
  wire [1:0] o_avs_response;
  wire [5:0] i_six_bit_port_pin, o_six_bit_port_pin;
  wire [5:0] o_six_bit_port_pin_oe, o_six_bit_port_pullup;
  wire [7:0] i_eight_bit_port_pin, o_eight_bit_port_pin;
  wire [7:0] o_eight_bit_port_pin_oe, o_eight_bit_port_pullup;
  wire [7:0] b_drv = o_eight_bit_port_pin & o_eight_bit_port_pin_oe;
  dgp_top dut (.i_mclk, .i_sys_rst, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
    .o_avs_waitrequest, .o_avs_response, .i_osc_is_rc_or_int,
    .i_undivided_osc_clock, .i_irq_pin_enable, .i_wakeup_request_latch,
    .i_six_bit_port_pin, .o_six_bit_port_pin, .o_six_bit_port_pin_oe,
    .o_six_bit_port_pullup, .i_eight_bit_port_pin, .o_eight_bit_port_pin,
    .o_eight_bit_port_pin_oe, .o_eight_bit_port_pullup);
  dgp_board #(.W(6)) brd_a (.i_mclk, .i_out(o_six_bit_port_pin),
    .i_oe(o_six_bit_port_pin_oe), .i_pullup(o_six_bit_port_pullup),
    .i_ext_en(a_en), .i_ext_val(a_val), .o_level(i_six_bit_port_pin));
  dgp_board #(.W(8)) brd_b (.i_mclk, .i_out(o_eight_bit_port_pin),
    .i_oe(o_eight_bit_port_pin_oe), .i_pullup(o_eight_bit_port_pullup),
    .i_ext_en(b_en), .i_ext_val(b_val), .o_level(i_eight_bit_port_pin));
  initial
    forever #2 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
    i_undivided_osc_clock <= ~i_undivided_osc_clock;
  task automatic results;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic acc(input bit w, input [3:0] a, input [7:0] d);
    i_avs_address <= a;
    i_avs_writedata <= {24'h000000, d};
    i_avs_write <= w;
    i_avs_read <= !w;
    @(posedge i_mclk);
    // no cycle limit here: only the watchdog ends a stuck wait
    while (o_avs_waitrequest !== 1'b0)
      @(posedge i_mclk);
    rdata = o_avs_readdata;
    rresp = o_avs_response;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic rchk(input [3:0] a, input [7:0] e, input string nm);
    acc(0, a, 8'h00);
    `CHK(nm, e, rdata[7:0])
  endtask
  task automatic do_rst;
    i_sys_rst <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
  endtask
  initial
  begin
    #20000;
    error_cnt++;
    results;
  end
  initial
  begin
    do_rst;
    for (int k = 4; k < 8; k++)
      rchk(k[3:0], 8'h00, "dir_pue_rst");
    acc(0, 4'h2, 8'h00);
    `CHK("unmapped", 34'h200000000, {rresp, rdata})
    $display("test reset done");
    b_en <= 8'hFF;
    b_val <= 8'h3C;
    acc(1, 4'h1, 8'hAA);
    rchk(4'h1, 8'h3C, "b_in");
    acc(1, 4'h5, 8'hF0);
    rchk(4'h1, 8'hAC, "b_mix");
    `CHK("b_out", 8'hA0, b_drv)
    b_en <= 8'h00;
    acc(1, 4'h7, 8'hFF);
    `CHK("b_pull", 8'h0F, o_eight_bit_port_pullup)
    rchk(4'h1, 8'hAF, "b_pulled");
    acc(1, 4'h7, 8'h00);
    `CHK("b_nopull", 8'h00, o_eight_bit_port_pullup)
    $display("test eight done");
    a_en <= 6'h3F;
    a_val <= 6'h15;
    acc(1, 4'h0, 8'h2A);
    acc(1, 4'h4, 8'h3F);
    rchk(4'h0, 8'h2E, "a_mix");
    `CHK("a_oe", 6'h3B, o_six_bit_port_pin_oe)
    acc(1, 4'h4, 8'h00);
    for (int k = 0; k < 6; k++)
    begin
      acc(1, 4'h6, 8'h01 << k);
      `CHK("a_pull", 6'h01 << k, o_six_bit_port_pullup)
    end
    acc(1, 4'h4, 8'h20);
    `CHK("a_pull_out", 6'h00, o_six_bit_port_pullup)
    i_irq_pin_enable <= 1'b1;
    i_wakeup_request_latch <= 1'b1;
    repeat (4) @(posedge i_mclk);
    rchk(4'h0, 8'h71, "irq_wake");
    i_irq_pin_enable <= 1'b0;
    i_wakeup_request_latch <= 1'b0;
    i_osc_is_rc_or_int <= 1'b1;
    acc(1, 4'h6, 8'h80);
    repeat (4)
    begin
      @(negedge i_mclk);
      `CHK("osc_pin", i_undivided_osc_clock, o_six_bit_port_pin[4])
      `CHK("osc_oe", 1'b1, o_six_bit_port_pin_oe[4])
    end
    @(posedge i_mclk);
    i_osc_is_rc_or_int <= 1'b0;
    @(negedge i_mclk);
    `CHK("osc_off", 1'b0, o_six_bit_port_pin_oe[4])
    @(posedge i_mclk);
    $display("test six done");
    // a second reset keeps the latches, so outputs show them again
    do_rst;
    acc(1, 4'h5, 8'hFF);
    rchk(4'h1, 8'hAA, "b_keep");
    acc(1, 4'h4, 8'h3F);
    rchk(4'h0, 8'h2E, "a_keep");
    $display("test latch done");
    results;
  end
endmodule
